// ===== design/cis_pkg.sv
// package: constants and cycle types of the interrupt and stack sequencer
package cis_pkg;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] STACK_RESET  = 16'h0000;

  // ------------------------------------------------------------------
  // machine cycle phases, one clock each
  // ------------------------------------------------------------------
  localparam logic [2:0] PH_SETUP  = 3'h0;
  localparam logic [2:0] PH_STROBE = 3'h1;
  localparam logic [2:0] PH_DATA   = 3'h2;
  localparam logic [2:0] PH_LAST   = 3'h4;

  // ------------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_LOAD_STK = 8'h31;
  localparam logic [7:0] OP_STA      = 8'h32;
  localparam logic [7:0] OP_INR_A    = 8'h3C;
  localparam logic [7:0] OP_MVI_A    = 8'h3E;
  localparam logic [7:0] OP_POP_B    = 8'hC1;
  localparam logic [7:0] OP_PUSH_B   = 8'hC5;
  localparam logic [7:0] OP_SUB_EXIT = 8'hC9;
  localparam logic [7:0] OP_OUT      = 8'hD3;
  localparam logic [7:0] OP_IN       = 8'hDB;
  localparam logic [7:0] OP_POP_PSW  = 8'hF1;
  localparam logic [7:0] OP_DI       = 8'hF3;
  localparam logic [7:0] OP_PUSH_PSW = 8'hF5;
  localparam logic [7:0] OP_IRQ_ON   = 8'hFB;
  localparam logic [7:0] RST_MASK    = 8'hC7;
  localparam logic [7:0] RST_MATCH   = 8'hC7;
  localparam logic [7:0] VEC_MASK    = 8'h38;

  // ------------------------------------------------------------------
  // status byte bit positions
  // ------------------------------------------------------------------
  localparam int ST_ACK    = 0;
  localparam int ST_WO_N   = 1;
  localparam int ST_STACK  = 2;
  localparam int ST_OUT    = 4;
  localparam int ST_FETCH  = 5;
  localparam int ST_IO_IN  = 6;
  localparam int ST_MEM_RD = 7;

  // ------------------------------------------------------------------
  // flag byte bit positions
  // ------------------------------------------------------------------
  localparam int FB_SIGN  = 7;
  localparam int FB_ZERO  = 6;
  localparam int FB_HALF  = 4;
  localparam int FB_PAR   = 2;
  localparam int FB_CARRY = 0;
  localparam logic [7:0] FB_FIXED = 8'h02;

  typedef enum logic [3:0] {
    CYC_FETCH, CYC_RD_LO, CYC_RD_HI, CYC_MEM_WR, CYC_IO_RD,
    CYC_IO_WR, CYC_PUSH_HI, CYC_PUSH_LO, CYC_POP_LO, CYC_POP_HI
  } cis_cycle_type;

endpackage : cis_pkg

// ===== design/cis_pin_if.sv
// interface: synchronised pin levels handed to the sequencer core
interface cis_pin_if;
  logic [7:0] data;
  logic       irq;
  modport source (output data, output irq);
  modport sink   (input data, input irq);
endinterface : cis_pin_if

// ===== design/cis_pin_sync.sv
// module: two-stage synchronisers for the data bus and interrupt pin
module cis_pin_sync (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // raw pins
  input  wire logic [7:0] data_in,
  input  wire logic       irq_line,
  // synchronised levels
  cis_pin_if.source       pins
);

  typedef struct packed {
    logic [7:0] data_1;
    logic [7:0] data_2;
    logic       irq_1;
    logic       irq_2;
  } cis_sync_type;

  cis_sync_type q;
  cis_sync_type next_q;

  // ------------------------------------------------------------------
  // first stage feeds only the second stage
  // ------------------------------------------------------------------
  always_comb begin
    next_q = q;
    if (clk_en) begin
      next_q.data_1 = data_in;
      next_q.data_2 = q.data_1;
      next_q.irq_1  = irq_line;
      next_q.irq_2  = q.irq_1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pins.data = q.data_2;
  assign pins.irq  = q.irq_2;

endmodule : cis_pin_sync

// ===== design/cis_sequencer.sv
// module: machine cycle, interrupt entry and stack sequencer of the cpu
// Function
// RL1: after reset the first access addresses memory location zero.
// RL2: each machine cycle opens with a status byte and status strobe.
// RL3: memory reads flag memory_read_status; data returns on the data bus.
// RL4: move-to-memory drives target address and data in the next cycle.
// RL5: memory writes happen only while store_strobe_n is low.
// RL6: io transfers put port number on address, flag io_in or out status.
// RL7: accepted interrupt gives irq_ack_status; supplied instruction is executed.
// RL8: acknowledge status is high when a pending request is accepted.
// RL9: up to five machine cycles; register and arithmetic ops finish in fetch.
// RL10: sixteen-bit stack_ptr points at the stack in memory.
// RL11: restart pushes the next program counter, then jumps to the vector.
// RL12: pushed flag byte: sign, zero, 0, half carry, 0, parity, 1, carry.
// RL13: irq_enable_op enables interrupt acceptance.
// RL14: acceptance disables interrupts until irq_enable_op runs again.
// RL15: popped registers are restored in last-in first-out order.
// RL16: return address plus one pair moves stack_ptr by four; return undoes it.
// RL17: return reloads the program counter from the stack.
// RL18: software loads stack_ptr with load_stack_ptr_imm before stack use.
// RL19: push predecrements stack_ptr per byte, pop postincrements per byte.
module cis_sequencer (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // address and data bus
  output logic      [15:0] addr,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  // cycle control
  output logic      [7:0]  status,
  output logic             status_strobe,
  output logic             read_strobe,
  output logic             store_strobe_n,
  // interrupt
  input  wire logic        irq_line,
  output logic             irq_enabled
);

  typedef struct packed {
    cis_pkg::cis_cycle_type cyc;
    logic [2:0]  phase;
    logic [15:0] pc;
    logic [15:0] stack_ptr;
    logic [15:0] addr;
    logic [7:0]  op;
    logic [7:0]  acc;
    logic [7:0]  reg_b;
    logic [7:0]  reg_c;
    logic [7:0]  tmp_lo;
    logic [7:0]  tmp_hi;
    logic [7:0]  dout;
    logic [7:0]  status;
    logic        negative_flag;
    logic        result_null_flag;
    logic        half_carry_flag;
    logic        even_ones_flag;
    logic        carry_out_flag;
    logic        inte;
    logic        int_cyc;
  } cis_state_type;

  cis_state_type q;
  cis_state_type next_q;
  logic          done;
  logic          fin;
  logic [7:0]    din;
  logic [7:0]    inc_acc;

  cis_pin_if pins ();

  cis_pin_sync u_sync (
    .clock    (clock),
    .reset    (reset),
    .clk_en   (clk_en),
    .data_in  (data_in),
    .irq_line (irq_line),
    .pins     (pins)
  );

  assign din  = pins.data;
  assign done = clk_en && (q.phase == cis_pkg::PH_LAST);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic is_rst(input logic [7:0] op);
    return (op & cis_pkg::RST_MASK) == cis_pkg::RST_MATCH;
  endfunction : is_rst

  function automatic logic is_write(input cis_pkg::cis_cycle_type c);
    return c == cis_pkg::CYC_MEM_WR || c == cis_pkg::CYC_IO_WR ||
           c == cis_pkg::CYC_PUSH_HI || c == cis_pkg::CYC_PUSH_LO;
  endfunction : is_write

  function automatic logic [7:0] flag_byte(input cis_state_type s);
    logic [7:0] b;
    b = cis_pkg::FB_FIXED;
    b[cis_pkg::FB_SIGN]  = s.negative_flag;
    b[cis_pkg::FB_ZERO]  = s.result_null_flag;
    b[cis_pkg::FB_HALF]  = s.half_carry_flag;
    b[cis_pkg::FB_PAR]   = s.even_ones_flag;
    b[cis_pkg::FB_CARRY] = s.carry_out_flag;
    return b;
  endfunction : flag_byte

  function automatic logic [7:0] status_of(input cis_pkg::cis_cycle_type c,
                                           input logic ic);
    logic [7:0] s;
    s = 8'h00;
    s[cis_pkg::ST_WO_N]  = !is_write(c);
    s[cis_pkg::ST_FETCH] = (c == cis_pkg::CYC_FETCH);
    s[cis_pkg::ST_ACK]   = (c == cis_pkg::CYC_FETCH) && ic;
    s[cis_pkg::ST_MEM_RD] = (c == cis_pkg::CYC_FETCH && !ic) || c == cis_pkg::CYC_RD_LO ||
                           c == cis_pkg::CYC_RD_HI || c == cis_pkg::CYC_POP_LO ||
                           c == cis_pkg::CYC_POP_HI;
    s[cis_pkg::ST_IO_IN] = (c == cis_pkg::CYC_IO_RD);
    s[cis_pkg::ST_OUT]   = (c == cis_pkg::CYC_IO_WR);
    s[cis_pkg::ST_STACK] = c == cis_pkg::CYC_PUSH_HI || c == cis_pkg::CYC_PUSH_LO ||
                           c == cis_pkg::CYC_POP_LO || c == cis_pkg::CYC_POP_HI;
    return s;
  endfunction : status_of

  assign inc_acc = q.acc + 8'h01;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_q = q;
    fin    = 1'b0;
    if (clk_en) begin
      next_q.phase = (q.phase == cis_pkg::PH_LAST) ? cis_pkg::PH_SETUP : q.phase + 3'h1;
      if (q.phase == cis_pkg::PH_SETUP) begin
        next_q.status = status_of(q.cyc, q.int_cyc); // RL2 RL3 RL6 RL7 RL8
        case (q.cyc)
          cis_pkg::CYC_FETCH, cis_pkg::CYC_RD_LO, cis_pkg::CYC_RD_HI: begin
            next_q.addr = q.pc; // RL1
          end
          cis_pkg::CYC_MEM_WR: begin
            next_q.addr = {q.tmp_hi, q.tmp_lo}; // RL4
            next_q.dout = q.acc;
          end
          cis_pkg::CYC_IO_RD, cis_pkg::CYC_IO_WR: begin
            next_q.addr = {q.tmp_lo, q.tmp_lo}; // RL6
            next_q.dout = q.acc;
          end
          cis_pkg::CYC_PUSH_HI: begin
            next_q.addr = q.stack_ptr; // RL10
            next_q.dout = q.tmp_hi;
          end
          cis_pkg::CYC_PUSH_LO: begin
            next_q.addr = q.stack_ptr;
            next_q.dout = q.tmp_lo;
          end
          default: begin
            next_q.addr = q.stack_ptr;
          end
        endcase
      end
      if (q.phase == cis_pkg::PH_LAST) begin
        case (q.cyc)
          cis_pkg::CYC_FETCH: begin
            next_q.op      = din;
            next_q.int_cyc = 1'b0;
            // an acknowledged instruction does not advance the counter
            if (!q.int_cyc) begin
              next_q.pc = q.pc + 16'h0001;
            end
            if (is_rst(din)) begin
              next_q.tmp_hi    = next_q.pc[15:8]; // RL11
              next_q.tmp_lo    = next_q.pc[7:0];
              next_q.stack_ptr = q.stack_ptr - 16'h0001; // RL19
              next_q.cyc       = cis_pkg::CYC_PUSH_HI;
            end else begin
              case (din)
                cis_pkg::OP_LOAD_STK, cis_pkg::OP_STA, cis_pkg::OP_MVI_A,
                cis_pkg::OP_IN, cis_pkg::OP_OUT: begin
                  next_q.cyc = cis_pkg::CYC_RD_LO; // RL9
                end
                cis_pkg::OP_PUSH_B: begin
                  next_q.tmp_hi    = q.reg_b;
                  next_q.tmp_lo    = q.reg_c;
                  next_q.stack_ptr = q.stack_ptr - 16'h0001; // RL19
                  next_q.cyc       = cis_pkg::CYC_PUSH_HI;
                end
                cis_pkg::OP_PUSH_PSW: begin
                  next_q.tmp_hi    = q.acc;
                  next_q.tmp_lo    = flag_byte(q); // RL12
                  next_q.stack_ptr = q.stack_ptr - 16'h0001; // RL19
                  next_q.cyc       = cis_pkg::CYC_PUSH_HI;
                end
                cis_pkg::OP_POP_B, cis_pkg::OP_POP_PSW, cis_pkg::OP_SUB_EXIT: begin
                  next_q.cyc = cis_pkg::CYC_POP_LO;
                end
                cis_pkg::OP_IRQ_ON: begin
                  next_q.inte = 1'b1; // RL13
                  fin         = 1'b1;
                end
                cis_pkg::OP_DI: begin
                  next_q.inte = 1'b0;
                  fin         = 1'b1;
                end
                cis_pkg::OP_INR_A: begin
                  next_q.acc              = inc_acc; // RL9
                  next_q.negative_flag    = inc_acc[7];
                  next_q.result_null_flag = (inc_acc == 8'h00);
                  next_q.half_carry_flag  = (q.acc[3:0] == 4'hF);
                  next_q.even_ones_flag   = ~^inc_acc;
                  fin                     = 1'b1;
                end
                default: begin
                  fin = 1'b1;
                end
              endcase
            end
          end
          cis_pkg::CYC_RD_LO: begin
            next_q.tmp_lo = din;
            next_q.pc     = q.pc + 16'h0001;
            if (q.op == cis_pkg::OP_MVI_A) begin
              next_q.acc = din;
              fin        = 1'b1;
            end else if (q.op == cis_pkg::OP_IN) begin
              next_q.cyc = cis_pkg::CYC_IO_RD;
            end else if (q.op == cis_pkg::OP_OUT) begin
              next_q.cyc = cis_pkg::CYC_IO_WR;
            end else begin
              next_q.cyc = cis_pkg::CYC_RD_HI;
            end
          end
          cis_pkg::CYC_RD_HI: begin
            next_q.tmp_hi = din;
            next_q.pc     = q.pc + 16'h0001;
            if (q.op == cis_pkg::OP_LOAD_STK) begin
              next_q.stack_ptr = {din, q.tmp_lo}; // RL18
              fin              = 1'b1;
            end else begin
              next_q.cyc = cis_pkg::CYC_MEM_WR; // RL4
            end
          end
          cis_pkg::CYC_IO_RD: begin
            next_q.acc = din;
            fin        = 1'b1;
          end
          cis_pkg::CYC_PUSH_HI: begin
            next_q.stack_ptr = q.stack_ptr - 16'h0001; // RL19
            next_q.cyc       = cis_pkg::CYC_PUSH_LO;
          end
          cis_pkg::CYC_PUSH_LO: begin
            if (is_rst(q.op)) begin
              next_q.pc = {8'h00, q.op & cis_pkg::VEC_MASK}; // RL11
            end
            fin = 1'b1;
          end
          cis_pkg::CYC_POP_LO: begin
            next_q.tmp_lo    = din;
            next_q.stack_ptr = q.stack_ptr + 16'h0001; // RL19
            next_q.cyc       = cis_pkg::CYC_POP_HI;
          end
          cis_pkg::CYC_POP_HI: begin
            next_q.stack_ptr = q.stack_ptr + 16'h0001; // RL16
            if (q.op == cis_pkg::OP_SUB_EXIT) begin
              next_q.pc = {din, q.tmp_lo}; // RL17
            end else if (q.op == cis_pkg::OP_POP_B) begin
              next_q.reg_b = din; // RL15
              next_q.reg_c = q.tmp_lo;
            end else begin
              next_q.acc              = din; // RL15
              next_q.negative_flag    = q.tmp_lo[cis_pkg::FB_SIGN];
              next_q.result_null_flag = q.tmp_lo[cis_pkg::FB_ZERO];
              next_q.half_carry_flag  = q.tmp_lo[cis_pkg::FB_HALF];
              next_q.even_ones_flag   = q.tmp_lo[cis_pkg::FB_PAR];
              next_q.carry_out_flag   = q.tmp_lo[cis_pkg::FB_CARRY];
            end
            fin = 1'b1;
          end
          default: begin
            fin = 1'b1;
          end
        endcase
        if (fin) begin
          next_q.cyc = cis_pkg::CYC_FETCH;
          // accepting a request masks further ones until re-enabled
          if (pins.irq && next_q.inte) begin
            next_q.int_cyc = 1'b1; // RL7 RL8
            next_q.inte    = 1'b0; // RL14
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q           <= '0;
      q.cyc       <= cis_pkg::CYC_FETCH;
      q.pc        <= cis_pkg::RESET_VECTOR; // RL1
      q.stack_ptr <= cis_pkg::STACK_RESET;
    end else begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------------
  // pins
  // ------------------------------------------------------------------
  assign addr           = q.addr;
  assign data_out       = q.dout;
  assign status         = q.status;
  assign irq_enabled    = q.inte;
  assign status_strobe  = (q.phase == cis_pkg::PH_STROBE); // RL2
  assign data_oe        = is_write(q.cyc) && (q.phase != cis_pkg::PH_SETUP);
  assign read_strobe    = !is_write(q.cyc) && (q.phase >= cis_pkg::PH_DATA);
  assign store_strobe_n = !(is_write(q.cyc) && (q.phase >= cis_pkg::PH_DATA)); // RL5

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  reset_fetch_a: assert property ($past(reset) |-> q.cyc == cis_pkg::CYC_FETCH && q.pc == 16'h0000) // RL1
    else $error("first fetch not at location zero");
  status_fetch_a: assert property (status_strobe && q.cyc == cis_pkg::CYC_FETCH
      |-> status[cis_pkg::ST_FETCH] && status[cis_pkg::ST_WO_N]) // RL2
    else $error("fetch status byte wrong");
  mem_read_a: assert property (read_strobe && q.cyc == cis_pkg::CYC_RD_LO
      |-> status[cis_pkg::ST_MEM_RD] && addr == q.pc) // RL3
    else $error("operand read without memory read status");
  store_window_a: assert property ($fell(store_strobe_n)
      |-> data_oe && !status[cis_pkg::ST_WO_N] ##1 !store_strobe_n ##1 !store_strobe_n ##1 store_strobe_n) // RL5
    else $error("store strobe window wrong");
  sta_target_a: assert property (done && q.cyc == cis_pkg::CYC_RD_HI && q.op == cis_pkg::OP_STA
      |=> ##1 addr == {q.tmp_hi, q.tmp_lo} && data_out == q.acc) // RL4
    else $error("store target or data wrong");
  io_port_a: assert property (status_strobe && q.cyc == cis_pkg::CYC_IO_RD
      |-> status[cis_pkg::ST_IO_IN] && addr[15:8] == addr[7:0]) // RL6
    else $error("input cycle without port address");
  irq_ack_a: assert property (status_strobe && q.int_cyc
      |-> status[cis_pkg::ST_ACK] && !status[cis_pkg::ST_MEM_RD] && !irq_enabled) // RL8
    else $error("acknowledge cycle wrong");
  push_dec_a: assert property (done && q.cyc == cis_pkg::CYC_PUSH_HI
      |=> q.stack_ptr == $past(q.stack_ptr) - 16'h0001) // RL19
    else $error("stack pointer not decremented");
  flag_byte_a: assert property (!store_strobe_n && q.cyc == cis_pkg::CYC_PUSH_LO
      && q.op == cis_pkg::OP_PUSH_PSW |-> data_out[1] && !data_out[3] && !data_out[5]) // RL12
    else $error("pushed flag byte malformed");
  enable_op_a: assert property (done && q.cyc == cis_pkg::CYC_FETCH && din == cis_pkg::OP_IRQ_ON
      && !pins.irq |=> irq_enabled) // RL13
    else $error("enable op did not enable");
  rst_vector_a: assert property (done && q.cyc == cis_pkg::CYC_PUSH_LO && is_rst(q.op)
      |=> q.pc == {8'h00, $past(q.op) & cis_pkg::VEC_MASK}) // RL11
    else $error("restart did not jump to vector");

  irq_cycle_c: cover property (status_strobe && q.int_cyc);
  rst_push_c: cover property (done && q.cyc == cis_pkg::CYC_PUSH_LO && is_rst(q.op));
  ret_pop_c: cover property (done && q.cyc == cis_pkg::CYC_POP_HI && q.op == cis_pkg::OP_SUB_EXIT);
  mem_write_c: cover property (!store_strobe_n && q.cyc == cis_pkg::CYC_MEM_WR);

endmodule : cis_sequencer

// ===== test/cis_mem_model.sv
// memory, io and interrupt-instruction model on the far side of the sequencer
module cis_mem_model #(
  parameter logic [7:0] IRQ_OP = 8'hFF
) (
  // clock
  input  wire logic        clock,
  // bus from the sequencer
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_out,
  input  wire logic [7:0]  status,
  input  wire logic        status_strobe,
  input  wire logic        read_strobe,
  input  wire logic        store_strobe_n,
  // bus to the sequencer
  output logic      [7:0]  data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] mem [0:65535];
  logic [7:0] latched = 8'h00;
  logic [7:0] last    = 8'h00;
  logic [7:0] rdval;

  // ------------------------------------------------------------------
  // status latch and read path
  // ------------------------------------------------------------------
  always @(posedge clock) begin
    if (status_strobe) latched <= status;
  end

  // io ports answer with the inverted port number so reads are not mistaken for memory
  always_comb begin
    if (latched[0]) rdval = IRQ_OP;
    else if (latched[6]) rdval = ~addr[7:0];
    else rdval = mem[addr];
  end

  // bus released outside the strobe: show the inverse of the last byte, no pull-up
  assign data_in = read_strobe ? rdval : ~last;

  // ------------------------------------------------------------------
  // write path
  // ------------------------------------------------------------------
  always @(posedge clock) begin
    if (read_strobe) last <= rdval;
    if (!store_strobe_n && !latched[4]) mem[addr] <= data_out;
  end
endmodule : cis_mem_model

// ===== test/tb_cpu_interrupt_stack_sequencer.sv
// self-checking bench: program run through fetch, io, stack and interrupt entry
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_cpu_interrupt_stack_sequencer;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, reset, clk_en, irq_line;
  logic [15:0] addr;
  logic [7:0] data_in, data_out, status;
  logic data_oe, status_strobe, read_strobe, store_strobe_n, irq_enabled;
  int mismatches = 0;
  int n_tests    = 0;
  logic [7:0] prog [0:15] = '{8'h31, 8'h00, 8'h20, 8'h3E, 8'h7F, 8'h3C, 8'hF5, 8'hDB,
                              8'h47, 8'hF1, 8'hD3, 8'h55, 8'h32, 8'h00, 8'h30, 8'hFB};

  cis_sequencer u_dut (
    .clock(clock), .reset(reset), .clk_en(clk_en), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .status(status), .status_strobe(status_strobe),
    .read_strobe(read_strobe), .store_strobe_n(store_strobe_n), .irq_line(irq_line),
    .irq_enabled(irq_enabled));

  cis_mem_model #(.IRQ_OP(8'hFF)) u_mem (
    .clock(clock), .addr(addr), .data_out(data_out), .status(status),
    .status_strobe(status_strobe), .read_strobe(read_strobe),
    .store_strobe_n(store_strobe_n), .data_in(data_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // bus cycle capture
  // ------------------------------------------------------------------
  // samples at phase 1 (address, status) and phase 2 (data, strobes)
  task automatic get_cycle(output logic [15:0] a, output logic [7:0] s, output logic [7:0] d,
                           output logic [1:0] strb);
    int n;
    n = 0;
    @(negedge clock);
    while (status_strobe !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) mismatches++;
    a = addr;
    s = status;
    @(negedge clock);
    d = data_oe ? data_out : data_in;
    strb = {read_strobe, store_strobe_n};
  endtask : get_cycle

  // read cycles: read strobe up, store strobe idle; write cycles: both low
  task automatic exp(input logic [15:0] ea, input logic [7:0] es, input logic [7:0] ed);
    logic [15:0] a;
    logic [7:0] s, d;
    logic [1:0] strb;
    get_cycle(a, s, d, strb);
    `CHK(a, ea)
    `CHK(s, es)
    `CHK(d, ed)
    `CHK(strb, (es[1] ? 2'b11 : 2'b00))
  endtask : exp

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_fetch();
    `CHK(irq_enabled, 1'b0)
    exp(16'h0000, 8'hA2, 8'h31);
    exp(16'h0001, 8'h82, 8'h00);
    exp(16'h0002, 8'h82, 8'h20);
    $display("test reset_fetch done");
  endtask : t_reset_fetch

  task automatic t_flags_push();
    exp(16'h0003, 8'hA2, 8'h3E);
    exp(16'h0004, 8'h82, 8'h7F);
    exp(16'h0005, 8'hA2, 8'h3C);
    exp(16'h0006, 8'hA2, 8'hF5);
    exp(16'h1FFF, 8'h04, 8'h80);
    exp(16'h1FFE, 8'h04, 8'h92);
    $display("test flags_push done");
  endtask : t_flags_push

  task automatic t_io_pop();
    exp(16'h0007, 8'hA2, 8'hDB);
    exp(16'h0008, 8'h82, 8'h47);
    exp(16'h4747, 8'h42, 8'hB8);
    exp(16'h0009, 8'hA2, 8'hF1);
    exp(16'h1FFE, 8'h86, 8'h92);
    exp(16'h1FFF, 8'h86, 8'h80);
    exp(16'h000A, 8'hA2, 8'hD3);
    exp(16'h000B, 8'h82, 8'h55);
    exp(16'h5555, 8'h10, 8'h80);
    $display("test io_pop done");
  endtask : t_io_pop

  task automatic t_store();
    exp(16'h000C, 8'hA2, 8'h32);
    exp(16'h000D, 8'h82, 8'h00);
    exp(16'h000E, 8'h82, 8'h30);
    exp(16'h3000, 8'h00, 8'h80);
    // memory takes the byte at the edge that ends the first strobe clock
    @(negedge clock);
    `CHK(u_mem.mem[16'h3000], 8'h80)
    $display("test store done");
  endtask : t_store

  task automatic t_interrupt();
    logic [15:0] a;
    logic [7:0] s, d;
    logic [1:0] strb;
    int n;
    exp(16'h000F, 8'hA2, 8'hFB);
    irq_line = 1'b1;
    n = 0;
    s = 8'h00;
    while (s[0] !== 1'b1 && n < 10) begin
      get_cycle(a, s, d, strb);
      n++;
    end
    irq_line = 1'b0;
    `CHK(a, 16'h0010)
    `CHK(s, 8'h23)
    `CHK(d, 8'hFF)
    `CHK(irq_enabled, 1'b0)
    exp(16'h1FFF, 8'h04, 8'h00);
    exp(16'h1FFE, 8'h04, 8'h10);
    exp(16'h0038, 8'hA2, 8'hF5);
    exp(16'h1FFD, 8'h04, 8'h80);
    exp(16'h1FFC, 8'h04, 8'h92);
    exp(16'h0039, 8'hA2, 8'hF1);
    exp(16'h1FFC, 8'h86, 8'h92);
    exp(16'h1FFD, 8'h86, 8'h80);
    exp(16'h003A, 8'hA2, 8'hFB);
    exp(16'h003B, 8'hA2, 8'hC9);
    `CHK(irq_enabled, 1'b1)
    exp(16'h1FFE, 8'h86, 8'h10);
    exp(16'h1FFF, 8'h86, 8'h00);
    exp(16'h0010, 8'hA2, 8'h00);
    $display("test interrupt done");
  endtask : t_interrupt

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    irq_line = 1'b0;
    for (int i = 0; i < 65536; i++) u_mem.mem[i] = 8'h00;
    for (int i = 0; i < 16; i++) u_mem.mem[i] = prog[i];
    u_mem.mem[16'h0038] = 8'hF5;
    u_mem.mem[16'h0039] = 8'hF1;
    u_mem.mem[16'h003A] = 8'hFB;
    u_mem.mem[16'h003B] = 8'hC9;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    t_reset_fetch();
    t_flags_push();
    t_io_pop();
    t_store();
    t_interrupt();
    print_verdict();
  end
endmodule : tb_cpu_interrupt_stack_sequencer
